/* design/scps_params.svh */
`ifndef SCPS_PARAMS_SVH
`define SCPS_PARAMS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define SCPS_OFF_LATENCY 8'h00
`define SCPS_OFF_STATUS1 8'h04
`define SCPS_OFF_UPSET 8'h08
`define SCPS_OFF_CALDLY 8'h0c
`define SCPS_OFF_TRIM 8'h10
`define SCPS_OFF_FLOW 8'h14
`define SCPS_OFF_CHIPID 8'h18

// ----------------------------------------------------------------
// Reset values and writable masks
// ----------------------------------------------------------------
`define SCPS_LAT_RESET 16'h00ff
`define SCPS_LAT_WMASK 16'hc2ff
`define SCPS_CALDLY_RESET 8'h00
`define SCPS_TRIM_RESET 12'h000
`define SCPS_UPSET_RESET 16'h0000

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SCPS_LAT_CMDONLY_BIT 9
`define SCPS_LAT_PBIST_BIT 14
`define SCPS_LAT_DBIST_BIT 15
`define SCPS_FLOW_BIT 9
`define SCPS_UPSET_PARITY_BIT 12
`define SCPS_UPSET_ANY_BIT 15

// ----------------------------------------------------------------
// Constants
// ----------------------------------------------------------------
`define SCPS_GLOBAL_ADDR 7'h7f
`define SCPS_STEP_TENTHS_00 4'h0
`define SCPS_STEP_TENTHS_01 4'h8
`define SCPS_STEP_TENTHS_10 4'ha
`define SCPS_STEP_TENTHS_11 4'hd
`define SCPS_ADDR_SETTLE 3'h4
`define SCPS_RESP_OKAY 2'h0
`define SCPS_RESP_SLVERR 2'h2

`endif

/* design/scps_pkg.sv */
package scps_pkg;

	// Clock rate seen by the serializer
	typedef enum logic [1:0] {
		SCPS_RATE_40 = 2'b00,
		SCPS_RATE_80 = 2'b01,
		SCPS_RATE_160 = 2'b10
	} scps_rate_t;

	// Live signals shown in the first status register
	typedef struct packed {
		logic derandSelftestFail;
		logic pipelineSelftestFail;
		logic derandOverflow;
		logic derandNotEmpty;
		logic regulatorOn;
		logic shuntOn;
		logic endMode;
		logic masterMode;
		logic badFastCommandCode;
		logic badSlowCommandCode;
		logic derandSelftestDone;
		logic pipelineSelftestDone;
	} scps_live_t;

	// One-cycle upset and parity events
	typedef struct packed {
		logic parityError;
		logic [9:0] upset;
	} scps_upset_t;

	// Redundant input set
	typedef struct packed {
		logic serializerClock;
		logic commandIn;
		logic crossingClock;
		logic triggerIn;
	} scps_link_t;

endpackage : scps_pkg

/* design/scps_pin_sync.sv */
`timescale 1ns/100ps

module scps_pin_sync #(
	parameter int WIDTH = 22
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Pins and clean levels
	input wire logic [WIDTH-1:0] pinIn,
	output logic [WIDTH-1:0] levelOut
);
	logic [WIDTH-1:0] stage1Reg;
	logic [WIDTH-1:0] stage2Reg;
	logic [WIDTH-1:0] stage3Reg;
	logic [WIDTH-1:0] levelNext;

	// A bit moves only when stages two and three agree
	assign levelNext = (stage2Reg & stage3Reg) | (levelOut & (stage2Reg ^ stage3Reg));

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			stage1Reg <= '0;
			stage2Reg <= '0;
			stage3Reg <= '0;
			levelOut <= '0;
		end else begin
			stage1Reg <= pinIn;
			stage2Reg <= stage1Reg;
			stage3Reg <= stage2Reg;
			levelOut <= levelNext;
		end
	end
endmodule : scps_pin_sync

/* design/scps_regs.sv */
// What this block does
// - Bit 9 set: trigger from commands only
// - Bits 14,15 enable pipeline, derandomizer self-test
// - First status register read-only, live, unstored
// - Status bits 0-3: self-test done, bad codes
// - Bits 4-10 rate, modes; bit 11 zero
// - Bits 12-15 not-empty, overflow, self-test results
// - Second status read-only, zero, soft-reset cleared
// - Bits 0-9 flag individual upsets
// - Bit 12 read parity, bit 15 any upset
// - Calibration delay: count, step; serial MSB first
// - Pulse delay in 64 count steps
// - Step code selects 0/0.8/1.0/1.3 ns
// - Trim value applied to addressed channel
// - Select low primary set, high reserve
// - Rate pins decode 40, 80, 160 MHz
// - Seven pulled-up pins give chip address
// - Address 1111111 is global, all respond
// - Direction low: bottom token in, top out
// - Direction low: bottom data out, top in
// - Flow direction bit 9 steers ports
//
// Added by the designer: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/100ps
`include "scps_params.svh"

module scps_regs (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// AXI4-Lite write channels
	input wire logic [7:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// AXI4-Lite read channels
	input wire logic [7:0] araddr,
	input wire logic [2:0] arprot,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Internal status sources
	input wire scps_pkg::scps_live_t liveStatus,
	input wire scps_pkg::scps_upset_t upsetEvents,
	input wire logic softResetCmd,
	input wire logic commandTrigger,
	// Calibration delay serial load
	input wire logic calSerialShift,
	input wire logic calSerialBit,
	// Redundant input sets and select pin
	input wire scps_pkg::scps_link_t linkPrimary,
	input wire scps_pkg::scps_link_t linkReserve,
	input wire logic selectReserve,
	// Rate and address pins
	input wire logic rateSelMid,
	input wire logic rateSelHigh,
	input wire logic [6:0] geographicAddressPins,
	input wire logic [6:0] commandAddress,
	// Token and data ports
	input wire logic bottomTokenPortIn,
	output logic bottomTokenPortOut,
	output logic bottomTokenPortOe,
	input wire logic topTokenPortIn,
	output logic topTokenPortOut,
	output logic topTokenPortOe,
	input wire logic bottomDataPortIn,
	output logic bottomDataPortOut,
	output logic bottomDataPortOe,
	input wire logic topDataPortIn,
	output logic topDataPortOut,
	output logic topDataPortOe,
	input wire logic tokenOutInt,
	input wire logic dataOutInt,
	output logic tokenInInt,
	output logic dataInInt,
	// Steered internal inputs
	output logic serializerClock,
	output logic commandIn,
	output logic crossingClock,
	output logic levelOneTrigger,
	// Configuration outputs
	output scps_pkg::scps_rate_t rateSetting,
	output logic [6:0] chipAddress,
	output logic addressHit,
	output logic pipelineSelftestEnable,
	output logic derandSelftestEnable,
	output logic commandOnlyTrigger,
	output logic [7:0] triggerLatency,
	output logic [5:0] calDelayCount,
	output logic [1:0] calStepCode,
	output logic [9:0] calDelayTenthsNs,
	output logic [4:0] trimValue,
	output logic [6:0] trimChannel,
	output logic trimLoad
);
	import scps_pkg::*;

	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------
	function automatic logic [15:0] mergeLanes(input logic [15:0] old, input logic [31:0] data,
		input logic [3:0] strb);
		mergeLanes = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
	endfunction : mergeLanes

	function automatic logic isMapped(input logic [7:0] addr);
		isMapped = (addr[1:0] == 2'b00) && (addr <= `SCPS_OFF_CHIPID);
	endfunction : isMapped

	function automatic logic [3:0] stepTenths(input logic [1:0] code);
		if (code == 2'b00) begin
			stepTenths = `SCPS_STEP_TENTHS_00;
		end else if (code == 2'b01) begin
			stepTenths = `SCPS_STEP_TENTHS_01;
		end else if (code == 2'b10) begin
			stepTenths = `SCPS_STEP_TENTHS_10;
		end else begin
			stepTenths = `SCPS_STEP_TENTHS_11;
		end
	endfunction : stepTenths

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [21:0] pinRaw;
	logic [21:0] pinLevel;
	scps_link_t primarySync;
	scps_link_t reserveSync;
	logic selectSync;
	logic rateMidSync;
	logic rateHighSync;
	logic [6:0] addrSync;
	logic [3:0] portSync;

	assign pinRaw = {linkPrimary, linkReserve, selectReserve, rateSelMid, rateSelHigh, geographicAddressPins,
		bottomTokenPortIn, topTokenPortIn, bottomDataPortIn, topDataPortIn};
	assign {primarySync, reserveSync, selectSync, rateMidSync, rateHighSync, addrSync, portSync} = pinLevel;

	scps_pin_sync #(.WIDTH(22)) pinSync (
		.clk(clk),
		.rstn(rstn),
		.pinIn(pinRaw),
		.levelOut(pinLevel)
	);

	// ----------------------------------------------------------------
	// Bus slave
	// ----------------------------------------------------------------
	logic awHeld;
	logic wHeld;
	logic arHeld;
	logic [7:0] awAddrReg;
	logic [31:0] wDataReg;
	logic [3:0] wStrbReg;
	logic [7:0] arAddrReg;
	logic awTake;
	logic wTake;
	logic arTake;
	logic doWrite;
	logic doRead;
	logic awHeldNext;
	logic wHeldNext;
	logic arHeldNext;

	assign awTake = awvalid && awready;
	assign wTake = wvalid && wready;
	assign arTake = arvalid && arready;
	// One write waits while its response is still unclaimed
	assign doWrite = awHeld && wHeld && !bvalid;
	assign doRead = arHeld && !rvalid;
	assign awHeldNext = (awHeld && !doWrite) || awTake;
	assign wHeldNext = (wHeld && !doWrite) || wTake;
	assign arHeldNext = (arHeld && !doRead) || arTake;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			awHeld <= 1'b0;
			wHeld <= 1'b0;
			arHeld <= 1'b0;
			awready <= 1'b0;
			wready <= 1'b0;
			arready <= 1'b0;
		end else begin
			awHeld <= awHeldNext;
			wHeld <= wHeldNext;
			arHeld <= arHeldNext;
			awready <= !awHeldNext;
			wready <= !wHeldNext;
			arready <= !arHeldNext;
		end
	end

	always_ff @(posedge clk) begin
		if (awTake) begin
			awAddrReg <= awaddr;
		end
		if (wTake) begin
			wDataReg <= wdata;
			wStrbReg <= wstrb;
		end
		if (arTake) begin
			arAddrReg <= araddr;
		end
	end

	// ----------------------------------------------------------------
	// Write decode
	// ----------------------------------------------------------------
	logic wrLatency;
	logic wrCalDelay;
	logic wrTrim;
	logic wrFlow;
	logic [15:0] latencyReg;
	logic [7:0] calDelayReg;
	logic [11:0] channel_threshold_trim;
	logic flowDirReg;
	logic [15:0] upsetReg;
	logic [15:0] latencyNext;
	logic [7:0] calDelayNext;
	logic [11:0] trimNext;
	logic flowDirNext;
	logic [15:0] upsetNext;
	logic [15:0] upsetSet;
	logic [15:0] calDelayMerged;
	logic [15:0] trimMerged;

	assign wrLatency = doWrite && (awAddrReg == `SCPS_OFF_LATENCY);
	assign wrCalDelay = doWrite && (awAddrReg == `SCPS_OFF_CALDLY);
	assign wrTrim = doWrite && (awAddrReg == `SCPS_OFF_TRIM);
	assign wrFlow = doWrite && (awAddrReg == `SCPS_OFF_FLOW);

	assign latencyNext = wrLatency ? (mergeLanes(latencyReg, wDataReg, wStrbReg) & `SCPS_LAT_WMASK) : latencyReg;
	assign calDelayMerged = mergeLanes({8'h00, calDelayReg}, wDataReg, wStrbReg);
	assign trimMerged = mergeLanes({4'h0, channel_threshold_trim}, wDataReg, wStrbReg);
	// Bus write outranks a serial shift arriving in the same cycle
	assign calDelayNext = wrCalDelay ? calDelayMerged[7:0]
		: (calSerialShift ? {calDelayReg[6:0], calSerialBit} : calDelayReg);
	assign trimNext = wrTrim ? trimMerged[11:0] : channel_threshold_trim;
	assign flowDirNext = (wrFlow && wStrbReg[1]) ? wDataReg[`SCPS_FLOW_BIT] : flowDirReg;

	// Events set after the soft clear, so a same-cycle upset survives
	assign upsetSet = {|upsetEvents.upset, 2'b00, upsetEvents.parityError, 2'b00, upsetEvents.upset};
	assign upsetNext = (softResetCmd ? `SCPS_UPSET_RESET : upsetReg) | upsetSet;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			latencyReg <= `SCPS_LAT_RESET;
			calDelayReg <= `SCPS_CALDLY_RESET;
			channel_threshold_trim <= `SCPS_TRIM_RESET;
			flowDirReg <= 1'b0;
			upsetReg <= `SCPS_UPSET_RESET;
		end else begin
			latencyReg <= latencyNext;
			calDelayReg <= calDelayNext;
			channel_threshold_trim <= trimNext;
			flowDirReg <= flowDirNext;
			upsetReg <= upsetNext;
		end
	end

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	logic [15:0] statusOneWord;
	logic [15:0] chipIdWord;
	logic [15:0] readWord;

	// Built from live inputs each read, nothing stored
	assign statusOneWord = {liveStatus.derandSelftestFail, liveStatus.pipelineSelftestFail,
		liveStatus.derandOverflow, liveStatus.derandNotEmpty, 1'b0, commandOnlyTrigger,
		liveStatus.regulatorOn, liveStatus.shuntOn, liveStatus.endMode, liveStatus.masterMode,
		rateSetting, liveStatus.badFastCommandCode, liveStatus.badSlowCommandCode,
		liveStatus.derandSelftestDone, liveStatus.pipelineSelftestDone};
	assign chipIdWord = {9'h000, chipAddress};

	always_comb begin
		if (arAddrReg == `SCPS_OFF_LATENCY) begin
			readWord = latencyReg;
		end else if (arAddrReg == `SCPS_OFF_STATUS1) begin
			readWord = statusOneWord;
		end else if (arAddrReg == `SCPS_OFF_UPSET) begin
			readWord = upsetReg;
		end else if (arAddrReg == `SCPS_OFF_CALDLY) begin
			readWord = {8'h00, calDelayReg};
		end else if (arAddrReg == `SCPS_OFF_TRIM) begin
			readWord = {4'h0, channel_threshold_trim};
		end else if (arAddrReg == `SCPS_OFF_FLOW) begin
			readWord = {6'h00, flowDirReg, 9'h000};
		end else if (arAddrReg == `SCPS_OFF_CHIPID) begin
			readWord = chipIdWord;
		end else begin
			readWord = 16'h0000;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			bvalid <= 1'b0;
			bresp <= `SCPS_RESP_OKAY;
			rvalid <= 1'b0;
			rresp <= `SCPS_RESP_OKAY;
			rdata <= 32'h00000000;
		end else begin
			if (doWrite) begin
				bvalid <= 1'b1;
				bresp <= isMapped(awAddrReg) ? `SCPS_RESP_OKAY : `SCPS_RESP_SLVERR;
			end else if (bready) begin
				bvalid <= 1'b0;
			end
			if (doRead) begin
				rvalid <= 1'b1;
				rresp <= isMapped(arAddrReg) ? `SCPS_RESP_OKAY : `SCPS_RESP_SLVERR;
				rdata <= {16'h0000, readWord};
			end else if (rready) begin
				rvalid <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Configuration outputs
	// ----------------------------------------------------------------
	scps_rate_t rateNext;
	logic [2:0] settleReg;
	logic addrLatched;

	// Both pins high falls back to the slowest rate
	assign rateNext = (rateMidSync && !rateHighSync) ? SCPS_RATE_80
		: ((!rateMidSync && rateHighSync) ? SCPS_RATE_160 : SCPS_RATE_40);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rateSetting <= SCPS_RATE_40;
			settleReg <= 3'h0;
			addrLatched <= 1'b0;
			chipAddress <= 7'h00;
			addressHit <= 1'b0;
			triggerLatency <= 8'hff;
			commandOnlyTrigger <= 1'b0;
			pipelineSelftestEnable <= 1'b0;
			derandSelftestEnable <= 1'b0;
			calDelayCount <= 6'h00;
			calStepCode <= 2'h0;
			calDelayTenthsNs <= 10'h000;
			trimValue <= 5'h00;
			trimChannel <= 7'h00;
			trimLoad <= 1'b0;
		end else begin
			rateSetting <= rateNext;
			// Address pins are caught once the synchroniser has settled
			if (!addrLatched) begin
				settleReg <= settleReg + 3'h1;
			end
			if (!addrLatched && settleReg == `SCPS_ADDR_SETTLE) begin
				addrLatched <= 1'b1;
				chipAddress <= addrSync;
			end
			addressHit <= addrLatched &&
				(commandAddress == chipAddress || commandAddress == `SCPS_GLOBAL_ADDR);
			triggerLatency <= latencyNext[7:0];
			commandOnlyTrigger <= latencyNext[`SCPS_LAT_CMDONLY_BIT];
			pipelineSelftestEnable <= latencyNext[`SCPS_LAT_PBIST_BIT];
			derandSelftestEnable <= latencyNext[`SCPS_LAT_DBIST_BIT];
			calDelayCount <= calDelayNext[5:0];
			calStepCode <= calDelayNext[7:6];
			calDelayTenthsNs <= 10'(calDelayNext[5:0]) * 10'(stepTenths(calDelayNext[7:6]));
			trimValue <= trimNext[4:0];
			trimChannel <= trimNext[11:5];
			trimLoad <= wrTrim;
		end
	end

	// ----------------------------------------------------------------
	// Input steering and port direction
	// ----------------------------------------------------------------
	scps_link_t chosenLink;

	assign chosenLink = selectSync ? reserveSync : primarySync;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			serializerClock <= 1'b0;
			commandIn <= 1'b0;
			crossingClock <= 1'b0;
			levelOneTrigger <= 1'b0;
			bottomTokenPortOe <= 1'b0;
			topTokenPortOe <= 1'b1;
			bottomDataPortOe <= 1'b1;
			topDataPortOe <= 1'b0;
			bottomTokenPortOut <= 1'b0;
			topTokenPortOut <= 1'b0;
			bottomDataPortOut <= 1'b0;
			topDataPortOut <= 1'b0;
			tokenInInt <= 1'b0;
			dataInInt <= 1'b0;
		end else begin
			serializerClock <= chosenLink.serializerClock;
			commandIn <= chosenLink.commandIn;
			crossingClock <= chosenLink.crossingClock;
			// The pin trigger is ignored in command-only mode
			levelOneTrigger <= commandOnlyTrigger ? commandTrigger : chosenLink.triggerIn;
			bottomTokenPortOe <= flowDirNext;
			topTokenPortOe <= !flowDirNext;
			bottomDataPortOe <= !flowDirNext;
			topDataPortOe <= flowDirNext;
			bottomTokenPortOut <= tokenOutInt;
			topTokenPortOut <= tokenOutInt;
			bottomDataPortOut <= dataOutInt;
			topDataPortOut <= dataOutInt;
			tokenInInt <= flowDirReg ? portSync[2] : portSync[3];
			dataInInt <= flowDirReg ? portSync[1] : portSync[0];
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	chk_cmd_only_trig: assert property (@(posedge clk) disable iff (!rstn)
		$past(commandOnlyTrigger) |-> levelOneTrigger == $past(commandTrigger))
		else $error("Pin trigger leaked in command-only mode");

	chk_selftest_enable: assert property (@(posedge clk) disable iff (!rstn)
		(wrLatency && wStrbReg[1]) |=> (pipelineSelftestEnable == $past(wDataReg[14])
		&& derandSelftestEnable == $past(wDataReg[15])))
		else $error("Self-test enables do not follow latency write");

	chk_status_one_live: assert property (@(posedge clk) disable iff (!rstn)
		(doRead && arAddrReg == `SCPS_OFF_STATUS1) |=> (rdata[11] == 1'b0
		&& rdata[12] == $past(liveStatus.derandNotEmpty) && rdata[0] == $past(liveStatus.pipelineSelftestDone)))
		else $error("First status word not live");

	chk_upset_sticky: assert property (@(posedge clk) disable iff (!rstn)
		(upsetEvents.upset[0] ##1 !softResetCmd) |-> (upsetReg[0] && upsetReg[`SCPS_UPSET_ANY_BIT]) [*2])
		else $error("Upset flag not held");

	chk_soft_clear: assert property (@(posedge clk) disable iff (!rstn)
		(softResetCmd && upsetEvents == '0) |=> upsetReg == 16'h0000)
		else $error("Soft reset did not clear upsets");

	chk_serial_msb: assert property (@(posedge clk) disable iff (!rstn)
		(calSerialShift && !wrCalDelay) |=> calDelayReg == {$past(calDelayReg[6:0]), $past(calSerialBit)})
		else $error("Serial load order wrong");

	chk_rate_fallback: assert property (@(posedge clk) disable iff (!rstn)
		(rateMidSync && rateHighSync) |=> rateSetting == SCPS_RATE_40)
		else $error("Rate fallback wrong");

	chk_global_addr: assert property (@(posedge clk) disable iff (!rstn)
		(addrLatched && commandAddress == `SCPS_GLOBAL_ADDR) |=> addressHit)
		else $error("Global address missed");

	chk_port_direction: assert property (@(posedge clk) disable iff (!rstn)
		$past(wrFlow && wStrbReg[1]) |-> (topTokenPortOe == !flowDirReg && bottomDataPortOe == !flowDirReg
		&& bottomTokenPortOe != topTokenPortOe && bottomDataPortOe != topDataPortOe))
		else $error("Port direction mismatch");

endmodule : scps_regs

/* testbench/scps_neighbour_model.sv */
`timescale 1ns/100ps

// ----------------------------------------------------------------
// Neighbour chip on one token or data wire
// ----------------------------------------------------------------
module scps_neighbour_model (
	// Chip side of the shared wire
	input wire logic chipOut,
	input wire logic chipOe,
	// Value the neighbour sends
	input wire logic sendBit,
	// Resolved wire level
	output logic wireLevel
);
	// Neighbour drives only while the chip listens on this side
	assign wireLevel = chipOe ? chipOut : sendBit;
endmodule : scps_neighbour_model

/* testbench/tb_top.sv */
`timescale 1ns/100ps
`include "scps_params.svh"

module tb_top;
	import scps_pkg::*;
	logic clk = 1'h0;
	logic rstn = 1'h0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [2:0] awprot = 3'h0, arprot = 3'h0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hf;
	logic awvalid = 1'h0, wvalid = 1'h0, arvalid = 1'h0, bready = 1'h1, rready = 1'h1;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	scps_live_t liveStatus = '0;
	scps_upset_t upsetEvents = '0;
	logic softResetCmd = 1'h0, commandTrigger = 1'h0, calSerialShift = 1'h0, calSerialBit = 1'h0;
	scps_link_t linkPrimary = 4'ha, linkReserve = 4'h5;
	logic selectReserve = 1'h0, rateSelMid = 1'h0, rateSelHigh = 1'h0;
	logic [6:0] geographicAddressPins = 7'h2a, commandAddress = 7'h00;
	logic tokenOutInt = 1'h0, dataOutInt = 1'h0;
	logic botTkSend = 1'h0, topTkSend = 1'h0, botDtSend = 1'h0, topDtSend = 1'h0;
	logic bottomTokenPortIn, topTokenPortIn, bottomDataPortIn, topDataPortIn;
	logic bottomTokenPortOut, bottomTokenPortOe, topTokenPortOut, topTokenPortOe;
	logic bottomDataPortOut, bottomDataPortOe, topDataPortOut, topDataPortOe;
	logic tokenInInt, dataInInt, serializerClock, commandIn, crossingClock, levelOneTrigger;
	scps_rate_t rateSetting;
	logic [6:0] chipAddress, trimChannel;
	logic addressHit, pipelineSelftestEnable, derandSelftestEnable, commandOnlyTrigger, trimLoad;
	logic [7:0] triggerLatency;
	logic [5:0] calDelayCount;
	logic [1:0] calStepCode;
	logic [9:0] calDelayTenthsNs;
	logic [4:0] trimValue;
	logic [1:0] rateExp [4] = '{2'h0, 2'h2, 2'h1, 2'h0};
	int stepTenths [4] = '{0, 8, 10, 13};
	int miscompares = 0;
	int samplesChecked = 0;

	scps_regs i_scps_regs (.*);
	scps_neighbour_model i_scps_neighbour_model_bt (.chipOut(bottomTokenPortOut), .chipOe(bottomTokenPortOe),
		.sendBit(botTkSend), .wireLevel(bottomTokenPortIn));
	scps_neighbour_model i_scps_neighbour_model_tt (.chipOut(topTokenPortOut), .chipOe(topTokenPortOe),
		.sendBit(topTkSend), .wireLevel(topTokenPortIn));
	scps_neighbour_model i_scps_neighbour_model_bd (.chipOut(bottomDataPortOut), .chipOe(bottomDataPortOe),
		.sendBit(botDtSend), .wireLevel(bottomDataPortIn));
	scps_neighbour_model i_scps_neighbour_model_td (.chipOut(topDataPortOut), .chipOe(topDataPortOe),
		.sendBit(topDtSend), .wireLevel(topDataPortIn));

	always #10 clk = ~clk;

	// ----------------------------------------------------------------
	// Bus and checking tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samplesChecked++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// Called right after a rising edge; ready sampled before that edge's updates
	task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, input logic [1:0] expResp);
		logic awDone;
		logic wDone;
		awDone = 1'h0;
		wDone = 1'h0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		while (!(awDone && wDone)) begin
			@(posedge clk);
			if (!awDone && awready) begin
				awDone = 1'h1;
				awvalid <= 1'h0;
			end
			if (!wDone && wready) begin
				wDone = 1'h1;
				wvalid <= 1'h0;
			end
		end
		@(posedge clk);
		while (!bvalid) @(posedge clk);
		chk(bresp, expResp);
	endtask : axiWrite

	task automatic axiRead(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] expResp);
		araddr <= a;
		arvalid <= 1'h1;
		@(posedge clk);
		while (!arready) @(posedge clk);
		arvalid <= 1'h0;
		@(posedge clk);
		while (!rvalid) @(posedge clk);
		chk(rdata, exp);
		chk(rresp, expResp);
	endtask : axiRead

	function automatic logic [31:0] live_status_one(input logic [11:0] l);
		return {16'h0, l[11:8], 2'h0, l[7:4], 2'h1, l[3:0]};
	endfunction : live_status_one

	task automatic endTest(input string name);
		$display("%s done, mismatches %0d", name, miscompares);
	endtask : endTest

	task automatic close_out;
		$display("checked %0d, mismatches %0d", samplesChecked, miscompares);
		if (miscompares == 0 && samplesChecked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : close_out

	// Whole run is a few hundred cycles
	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		close_out;
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (8) @(posedge clk);
		rstn <= 1'h1;
		repeat (8) @(posedge clk);
		axiRead(`SCPS_OFF_LATENCY, 32'h00ff, `SCPS_RESP_OKAY);
		axiRead(`SCPS_OFF_UPSET, 32'h0, `SCPS_RESP_OKAY);
		axiRead(`SCPS_OFF_CALDLY, 32'h0, `SCPS_RESP_OKAY);
		axiRead(`SCPS_OFF_TRIM, 32'h0, `SCPS_RESP_OKAY);
		axiRead(`SCPS_OFF_CHIPID, 32'h2a, `SCPS_RESP_OKAY);
		chk(chipAddress, 7'h2a);
		endTest("reset");
		axiWrite(`SCPS_OFF_LATENCY, 32'hffffffff, `SCPS_RESP_OKAY);
		axiRead(`SCPS_OFF_LATENCY, 32'hc2ff, `SCPS_RESP_OKAY);
		chk({pipelineSelftestEnable, derandSelftestEnable, commandOnlyTrigger, triggerLatency}, 11'h7ff);
		commandTrigger <= 1'h1;
		linkPrimary.triggerIn <= 1'h1;
		repeat (8) @(posedge clk);
		chk(levelOneTrigger, 1'h1);
		commandTrigger <= 1'h0;
		repeat (3) @(posedge clk);
		chk(levelOneTrigger, 1'h0);
		linkPrimary.triggerIn <= 1'h0;
		axiWrite(`SCPS_OFF_LATENCY, 32'h00ff, `SCPS_RESP_OKAY);
		repeat (8) @(posedge clk);
		chk({serializerClock, commandIn, crossingClock, levelOneTrigger}, 4'ha);
		selectReserve <= 1'h1;
		repeat (8) @(posedge clk);
		chk({serializerClock, commandIn, crossingClock, levelOneTrigger}, 4'h5);
		selectReserve <= 1'h0;
		for (int i = 0; i < 4; i++) begin
			{rateSelMid, rateSelHigh} <= 2'(i);
			repeat (8) @(posedge clk);
			chk(rateSetting, rateExp[i]);
		end
		endTest("trigger, steering, rate");
		{rateSelMid, rateSelHigh} <= 2'h2;
		liveStatus <= 12'hb5a;
		repeat (8) @(posedge clk);
		axiRead(`SCPS_OFF_STATUS1, live_status_one(12'hb5a), `SCPS_RESP_OKAY);
		axiWrite(`SCPS_OFF_STATUS1, 32'hffff, `SCPS_RESP_OKAY);
		liveStatus <= 12'h4a5;
		repeat (3) @(posedge clk);
		axiRead(`SCPS_OFF_STATUS1, live_status_one(12'h4a5), `SCPS_RESP_OKAY);
		upsetEvents <= 11'h609;
		@(posedge clk);
		upsetEvents <= '0;
		repeat (2) @(posedge clk);
		axiRead(`SCPS_OFF_UPSET, 32'h9209, `SCPS_RESP_OKAY);
		axiWrite(`SCPS_OFF_UPSET, 32'h0, `SCPS_RESP_OKAY);
		axiRead(`SCPS_OFF_UPSET, 32'h9209, `SCPS_RESP_OKAY);
		softResetCmd <= 1'h1;
		@(posedge clk);
		softResetCmd <= 1'h0;
		repeat (2) @(posedge clk);
		axiRead(`SCPS_OFF_UPSET, 32'h0, `SCPS_RESP_OKAY);
		endTest("status");
		for (int c = 0; c < 4; c++) begin
			axiWrite(`SCPS_OFF_CALDLY, {24'h0, 2'(c), 6'h3f}, `SCPS_RESP_OKAY);
			repeat (2) @(posedge clk);
			chk({calStepCode, calDelayCount, calDelayTenthsNs}, {2'(c), 6'h3f, 10'(63 * stepTenths[c])});
		end
		axiWrite(`SCPS_OFF_CALDLY, 32'hffff, `SCPS_RESP_OKAY);
		axiRead(`SCPS_OFF_CALDLY, 32'h00ff, `SCPS_RESP_OKAY);
		for (int i = 7; i >= 0; i--) begin
			calSerialBit <= 1'(8'h9c >> i);
			calSerialShift <= 1'h1;
			@(posedge clk);
		end
		calSerialShift <= 1'h0;
		repeat (2) @(posedge clk);
		axiRead(`SCPS_OFF_CALDLY, 32'h9c, `SCPS_RESP_OKAY);
		axiWrite(`SCPS_OFF_TRIM, 32'hffffabcd, `SCPS_RESP_OKAY);
		chk(trimLoad, 1'h1);
		axiRead(`SCPS_OFF_TRIM, 32'h0bcd, `SCPS_RESP_OKAY);
		chk({trimChannel, trimValue}, 12'hbcd);
		endTest("calibration, trim");
		commandAddress <= 7'h2a;
		repeat (3) @(posedge clk);
		chk(addressHit, 1'h1);
		commandAddress <= 7'h7f;
		repeat (3) @(posedge clk);
		chk(addressHit, 1'h1);
		commandAddress <= 7'h2b;
		repeat (3) @(posedge clk);
		chk(addressHit, 1'h0);
		tokenOutInt <= 1'h1;
		botTkSend <= 1'h1;
		botDtSend <= 1'h1;
		topDtSend <= 1'h1;
		repeat (8) @(posedge clk);
		chk({bottomTokenPortOe, topTokenPortOe, bottomDataPortOe, topDataPortOe, tokenInInt, topTokenPortIn,
			dataInInt, bottomDataPortIn}, 8'h6e);
		axiWrite(`SCPS_OFF_FLOW, 32'h0200, `SCPS_RESP_OKAY);
		repeat (8) @(posedge clk);
		chk({bottomTokenPortOe, topTokenPortOe, bottomDataPortOe, topDataPortOe, tokenInInt, bottomTokenPortIn,
			dataInInt, topDataPortIn}, 8'h96);
		axiWrite(8'h40, 32'h1, `SCPS_RESP_SLVERR);
		axiRead(8'h40, 32'h0, `SCPS_RESP_SLVERR);
		endTest("address, ports, unmapped");
		close_out;
	end
endmodule : tb_top
